// File: host_model.sv
/*
 * Host side model: drives the host ready level and a free running
 * operation cycle tick.
 * Assumes the bench asks for ready through ready_req on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module host_model #(
	parameter int TICK_P = 5
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bench request
	input wire logic ready_req,
	// To the device
	output logic host_ready_flag,
	output logic op_cycle_tick
);
	int cnt;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			host_ready_flag <= 1'b0;
			op_cycle_tick <= 1'b0;
			cnt <= 0;
		end else begin
			host_ready_flag <= ready_req;
			cnt <= (cnt == TICK_P - 1) ? 0 : cnt + 1;
			// Ticks run free, so many land while not ready
			op_cycle_tick <= (cnt == TICK_P - 1);
		end
	end
endmodule // host_model

`default_nettype wire

// File: limit_point_eval.sv
/*
 * One limit switch point: signed region compare of a watch value against its
 * on/off thresholds, gated by the optional enable bit and the optional forced bit.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none

module limit_point_eval
	import limit_switch_pkg::*;
(
	// Point setup
	input wire logic point_used,
	input wire logic [DTYPE_W-1:0] data_type,
	// Values
	input wire logic [WORD_W-1:0] watch_value,
	input wire logic [WORD_W-1:0] on_value,
	input wire logic [WORD_W-1:0] off_value,
	// Gating bits
	input wire logic enable_used,
	input wire logic enable_bit,
	input wire logic force_used,
	input wire logic force_bit,
	// Result
	output logic hit
);

	// Map each type onto an unsigned key that sorts like the signed value,
	// so one unsigned comparator serves integers and floats alike
	function automatic logic [WORD_W-1:0] order_key(input logic [DTYPE_W-1:0] dt, input logic [WORD_W-1:0] v);
		logic [WORD_W-1:0] k;
		k = WORD_RESET;
		case (dt)
			DT_INT16: k = {{48{v[15]}}, v[15:0]} ^ KEY_FLIP;
			DT_FLOAT64: k = v[63] ? ~v : (v ^ KEY_FLIP);
			default: k = {{32{v[31]}}, v[31:0]} ^ KEY_FLIP;
		endcase
		return k;
	endfunction

	logic [WORD_W-1:0] watch_key;
	logic [WORD_W-1:0] on_key;
	logic [WORD_W-1:0] off_key;
	logic in_region;
	logic enabled;
	logic forced;

	// Thresholds take the watch value's type
	assign watch_key = order_key(data_type, watch_value);
	assign on_key = order_key(data_type, on_value);
	assign off_key = order_key(data_type, off_value);

	always_comb begin
		if (on_key < off_key) begin
			in_region = (watch_key >= on_key) && (watch_key < off_key);
		end else if (on_key > off_key) begin
			in_region = (watch_key >= on_key) || (watch_key < off_key);
		end else begin
			in_region = 1'b0;
		end
	end

	assign enabled = !enable_used || enable_bit;
	assign forced = force_used && force_bit;
	assign hit = point_used && (forced || (enabled && in_region));

endmodule // limit_point_eval

`default_nettype wire

// File: limit_switch_output.sv
/*
 * Limit switch output unit: up to 32 points compared against signed on/off
 * thresholds once per operation cycle, ORed onto shared output bits.
 * Assumes host_ready_flag, op_cycle_tick and all setup and data inputs come
 * from logic on clk; the setup is held steady by the host while in use.
 */
`timescale 1ns/10ps
`default_nettype none

module limit_switch_output
	import limit_switch_pkg::*;
#(
	parameter int NUM_POINTS = DEF_POINTS,
	parameter int NUM_OUTPUTS = DEF_OUTPUTS,
	parameter int OSEL_W = (NUM_OUTPUTS > 1) ? $clog2(NUM_OUTPUTS) : 1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Host handshake and cycle timing
	input wire logic host_ready_flag,
	input wire logic op_cycle_tick,
	// Point setup
	input wire logic [NUM_POINTS-1:0] point_used,
	input wire logic [NUM_POINTS-1:0][OSEL_W-1:0] point_out_sel,
	input wire logic [NUM_POINTS-1:0][DTYPE_W-1:0] point_data_type,
	input wire logic [NUM_POINTS-1:0] thr_from_word,
	input wire logic [NUM_POINTS-1:0] enable_used,
	input wire logic [NUM_POINTS-1:0] force_used,
	// Live data: watch values, word thresholds, constants, gating bits
	input wire logic [NUM_POINTS-1:0][WORD_W-1:0] watch_value,
	input wire logic [NUM_POINTS-1:0][WORD_W-1:0] on_word,
	input wire logic [NUM_POINTS-1:0][WORD_W-1:0] off_word,
	input wire logic [NUM_POINTS-1:0][WORD_W-1:0] on_const,
	input wire logic [NUM_POINTS-1:0][WORD_W-1:0] off_const,
	input wire logic [NUM_POINTS-1:0] enable_bit,
	input wire logic [NUM_POINTS-1:0] force_bit,
	// Status and outputs
	output logic ready_complete_flag,
	output logic [NUM_OUTPUTS-1:0] limit_out
);

	// Refuse sizes the selector and the point table cannot serve
	if (NUM_POINTS < 1 || NUM_POINTS > MAX_POINTS) begin : g_bad_points
		$error("NUM_POINTS must be 1 to 32");
	end
	if (NUM_OUTPUTS < 1 || (1 << OSEL_W) < NUM_OUTPUTS) begin : g_bad_outputs
		$error("NUM_OUTPUTS does not fit the output selector");
	end

	logic host_ready_prev_reg;
	logic ready_complete_reg;
	logic eval_pending_reg;
	logic seen_rise_reg;
	logic [NUM_OUTPUTS-1:0] limit_out_reg;
	logic [NUM_OUTPUTS-1:0] limit_out_next;
	logic [NUM_POINTS-1:0][WORD_W-1:0] on_store_reg;
	logic [NUM_POINTS-1:0][WORD_W-1:0] off_store_reg;
	logic [NUM_POINTS-1:0] point_hit;
	logic ready_rise;
	logic cycle_go;

	assign ready_rise = host_ready_flag && !host_ready_prev_reg;
	assign cycle_go = op_cycle_tick && ready_complete_reg && host_ready_flag;

	// Handshake tracking
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			host_ready_prev_reg <= 1'b0;
		end else begin
			host_ready_prev_reg <= host_ready_flag;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_complete_reg <= 1'b0;
		end else if (ready_rise) begin
			ready_complete_reg <= 1'b1;
		end else if (!host_ready_flag) begin
			ready_complete_reg <= 1'b0;
		end
	end

	// Remembers that a handshake has ever completed since reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seen_rise_reg <= 1'b0;
		end else if (ready_rise) begin
			seen_rise_reg <= 1'b1;
		end
	end

	// Threshold storage: every point is loaded at the rise, word-sourced ones
	// again on each operation cycle; constants never change after the rise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			on_store_reg <= '0;
			off_store_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_POINTS; i++) begin
				if (ready_rise) begin
					on_store_reg[i] <= thr_from_word[i] ? on_word[i] : on_const[i];
					off_store_reg[i] <= thr_from_word[i] ? off_word[i] : off_const[i];
				end else if (cycle_go && thr_from_word[i]) begin
					on_store_reg[i] <= on_word[i];
					off_store_reg[i] <= off_word[i];
				end
			end
		end
	end

	// Outputs follow one clock after the refresh so they see the new thresholds
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eval_pending_reg <= 1'b0;
		end else begin
			eval_pending_reg <= cycle_go || ready_rise;
		end
	end

	// One evaluator per point
	for (genvar p = 0; p < NUM_POINTS; p++) begin : g_point
		limit_point_eval u_eval (
			.point_used(point_used[p]),
			.data_type(point_data_type[p]),
			.watch_value(watch_value[p]),
			.on_value(on_store_reg[p]),
			.off_value(off_store_reg[p]),
			.enable_used(enable_used[p]),
			.enable_bit(enable_bit[p]),
			.force_used(force_used[p]),
			.force_bit(force_bit[p]),
			.hit(point_hit[p])
		);
	end

	// Gather every point aimed at each output bit
	always_comb begin
		limit_out_next = '0;
		for (int i = 0; i < NUM_POINTS; i++) begin
			if (point_hit[i] && (int'(point_out_sel[i]) < NUM_OUTPUTS)) begin
				limit_out_next[point_out_sel[i]] = 1'b1;
			end
		end
	end

	// A host drop clears at once instead of waiting for the next tick
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			limit_out_reg <= '0;
		end else if (!host_ready_flag || !ready_complete_reg) begin
			limit_out_reg <= '0;
		end else if (eval_pending_reg) begin
			limit_out_reg <= limit_out_next;
		end
	end

	assign ready_complete_flag = ready_complete_reg;
	assign limit_out = limit_out_reg;

	// Checks; those tied to one point use point 0 as a representative of the table
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_cycle_start;
		op_cycle_tick && ready_complete_reg && host_ready_flag;
	endsequence

	sequence s_eval_step;
		eval_pending_reg && host_ready_flag;
	endsequence

	sequence s_host_drop;
		ready_complete_reg ##1 !host_ready_flag;
	endsequence

	a_idle_outputs_off: assert property (!ready_complete_reg |=> (limit_out_reg == '0) || ready_complete_reg)
		else $error("limit outputs active without ready complete");

	a_drop_clears_all: assert property (s_host_drop |=> (limit_out_reg == '0) && !ready_complete_reg)
		else $error("outputs not cleared after host ready drop");

	a_rise_captures: assert property (ready_rise |=>
		on_store_reg[0] == ($past(thr_from_word[0]) ? $past(on_word[0]) : $past(on_const[0])))
		else $error("threshold not captured at host ready rise");

	a_tick_refresh: assert property ((s_cycle_start ##0 (thr_from_word[0] && !ready_rise)) |=>
		(on_store_reg[0] == $past(on_word[0])) && (off_store_reg[0] == $past(off_word[0])))
		else $error("word threshold not refreshed on operation cycle");

	a_eval_follows: assert property (s_cycle_start ##1 s_eval_step |=> limit_out_reg == $past(limit_out_next))
		else $error("outputs not updated one clock after refresh");

	a_force_wins: assert property ((eval_pending_reg && host_ready_flag && ready_complete_reg && point_used[0]
		&& force_used[0] && force_bit[0] && int'(point_out_sel[0]) < NUM_OUTPUTS) |=> limit_out_reg[$past(point_out_sel[0])])
		else $error("forced point did not drive its output");

	a_disabled_off: assert property ((enable_used[0] && !enable_bit[0] && !(force_used[0] && force_bit[0])) |-> !point_hit[0])
		else $error("disabled point reported a hit");

	a_equal_region: assert property ((on_store_reg[0] == off_store_reg[0] && !(force_used[0] && force_bit[0])) |-> !point_hit[0])
		else $error("equal thresholds produced a hit");

	a_reset_store: assert property (!seen_rise_reg |-> (on_store_reg[0] == WORD_RESET) && (limit_out_reg == '0))
		else $error("storage or outputs set before first handshake");

	// Plain signed reference for the integer types, kept apart from the sort key mapping
	function automatic logic ref_region(input logic signed [31:0] w, input logic signed [31:0] on_v,
		input logic signed [31:0] off_v);
		if (on_v < off_v) begin
			return (w >= on_v) && (w < off_v);
		end
		if (on_v > off_v) begin
			return (w >= on_v) || (w < off_v);
		end
		return 1'b0;
	endfunction

	sequence s_rise_seen;
		host_ready_flag && !host_ready_prev_reg;
	endsequence

	sequence s_live_hold;
		!eval_pending_reg && host_ready_flag && ready_complete_reg;
	endsequence

	sequence s_point0_plain;
		point_used[0] && !(force_used[0] && force_bit[0]) && (!enable_used[0] || enable_bit[0]);
	endsequence

	a_rise_sets_ready: assert property (s_rise_seen |=> ready_complete_reg)
		else $error("ready complete not set after host ready rise");

	a_ready_needs_host: assert property (ready_complete_reg |-> host_ready_prev_reg)
		else $error("ready complete set while host ready was low");

	a_tick_ignored: assert property ((op_cycle_tick && !ready_complete_reg) |=>
		eval_pending_reg == $past(ready_rise))
		else $error("operation cycle taken before ready complete");

	a_drop_clears_now: assert property (!host_ready_flag |=> (limit_out_reg == '0) && !ready_complete_reg)
		else $error("outputs still on one clock after host ready low");

	a_rise_captures_off: assert property (s_rise_seen |=>
		off_store_reg[0] == ($past(thr_from_word[0]) ? $past(off_word[0]) : $past(off_const[0])))
		else $error("off threshold not captured at host ready rise");

	a_const_kept: assert property ((s_cycle_start ##0 !thr_from_word[0]) |=>
		$stable(on_store_reg[0]) && $stable(off_store_reg[0]))
		else $error("constant threshold reloaded on operation cycle");

	a_stores_idle: assert property ((!ready_rise && !cycle_go) |=>
		$stable(on_store_reg) && $stable(off_store_reg))
		else $error("thresholds changed outside rise or operation cycle");

	a_outputs_hold: assert property (s_live_hold |=> $stable(limit_out_reg))
		else $error("outputs changed between operation cycles");

	a_hit_drives_out: assert property ((s_eval_step ##0 (ready_complete_reg && point_hit[0]
		&& int'(point_out_sel[0]) < NUM_OUTPUTS)) |=> limit_out_reg[$past(point_out_sel[0])])
		else $error("point hit lost in the shared output OR");

	a_unforced_bit: assert property ((!force_used[0] && force_bit[0]
		&& enable_used[0] && !enable_bit[0]) |-> !point_hit[0])
		else $error("unconfigured forced bit drove a point");

	a_int32_region: assert property ((s_point0_plain ##0 (point_data_type[0] == DT_INT32)) |->
		point_hit[0] == ref_region(watch_value[0][31:0],
		on_store_reg[0][31:0], off_store_reg[0][31:0]))
		else $error("32-bit signed region result wrong");

	a_int16_region: assert property ((s_point0_plain ##0 (point_data_type[0] == DT_INT16)) |->
		point_hit[0] == ref_region(32'(signed'(watch_value[0][15:0])),
		32'(signed'(on_store_reg[0][15:0])), 32'(signed'(off_store_reg[0][15:0]))))
		else $error("16-bit signed region result wrong");

	// Use and force gating hold for every point of the table, not only the sample point
	for (genvar q = 0; q < NUM_POINTS; q++) begin : g_point_chk
		a_unused_quiet: assert property (!point_used[q] |-> !point_hit[q])
			else $error("unused point reported a hit");
		a_forced_on: assert property ((point_used[q] && force_used[q] && force_bit[q]) |-> point_hit[q])
			else $error("forced point reported no hit");
	end

endmodule // limit_switch_output

`default_nettype wire

// File: limit_switch_pkg.sv
/*
 * Shared constants of the limit switch output unit: point counts, word width
 * and the encoding of the comparison data type.
 * Assumes nothing of its surroundings; compiled before the design modules.
 */
`default_nettype none

package limit_switch_pkg;

	// Point and output counts
	localparam int MAX_POINTS = 32;
	localparam int DEF_POINTS = 32;
	localparam int DEF_OUTPUTS = 32;

	// Word data is carried at its widest form, the 64-bit float
	localparam int WORD_W = 64;
	localparam logic [WORD_W-1:0] WORD_RESET = 64'h0000000000000000;
	localparam logic [WORD_W-1:0] KEY_FLIP = 64'h8000000000000000;

	// Comparison data type of a point
	localparam int DTYPE_W = 2;
	localparam logic [DTYPE_W-1:0] DT_INT16 = 2'h0;
	localparam logic [DTYPE_W-1:0] DT_INT32 = 2'h1;
	localparam logic [DTYPE_W-1:0] DT_FLOAT64 = 2'h2;

endpackage

`default_nettype wire

// File: tb.sv
/*
 * Testbench: random setup and live data, cycle model compared every cycle.
 * Assumes host_model drives the handshake and the tick.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
	import limit_switch_pkg::*;
	localparam int P = 4;
	localparam int NO = 3;
	logic clk = 1'b0;
	logic resetn, ready_req, hrf, tick, rcf;
	logic [NO-1:0] lo, m_out;
	logic [P-1:0] pu, tw, eu, fu, eb, fb;
	logic [P-1:0][1:0] sel;
	logic [P-1:0][DTYPE_W-1:0] dt;
	logic [P-1:0][WORD_W-1:0] wv, onw, offw, onc, offc, s_on, s_off;
	logic m_prev, m_rc, m_ev;
	int n_fail = 0;
	int tests_run = 0;

	always #4 clk = ~clk;

	host_model #(.TICK_P(5)) host_model_inst (.clk(clk), .resetn(resetn), .ready_req(ready_req),
		.host_ready_flag(hrf), .op_cycle_tick(tick));

	limit_switch_output #(.NUM_POINTS(P), .NUM_OUTPUTS(NO), .OSEL_W(2)) limit_switch_output_inst (
		.clk(clk), .resetn(resetn), .host_ready_flag(hrf), .op_cycle_tick(tick), .point_used(pu),
		.point_out_sel(sel), .point_data_type(dt), .thr_from_word(tw), .enable_used(eu),
		.force_used(fu), .watch_value(wv), .on_word(onw), .off_word(offw), .on_const(onc),
		.off_const(offc), .enable_bit(eb), .force_bit(fb), .ready_complete_flag(rcf), .limit_out(lo));

	function automatic real num(input logic [WORD_W-1:0] x, input logic [DTYPE_W-1:0] t);
		if (t == DT_INT16) return real'($signed(x[15:0]));
		if (t == DT_FLOAT64) return $bitstoreal(x);
		return real'($signed(x[31:0]));
	endfunction

	function automatic logic [NO-1:0] exp_out();
		logic [NO-1:0] r;
		real w, a, b;
		logic hit;
		r = '0;
		for (int p = 0; p < P; p++) begin
			w = num(wv[p], dt[p]);
			a = num(s_on[p], dt[p]);
			b = num(s_off[p], dt[p]);
			hit = (a < b) ? (w >= a && w < b) : (a > b) ? (w >= a || w < b) : 1'b0;
			if (pu[p] && sel[p] < NO && ((fu[p] && fb[p]) || ((!eu[p] || eb[p]) && hit)))
				r[sel[p]] = 1'b1;
		end
		return r;
	endfunction

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			m_prev <= 1'b0;
			m_rc <= 1'b0;
			m_ev <= 1'b0;
			m_out <= '0;
			s_on <= '0;
			s_off <= '0;
		end else begin
			m_prev <= hrf;
			m_rc <= hrf && (m_rc || !m_prev);
			m_ev <= hrf && (!m_prev || (tick && m_rc));
			for (int p = 0; p < P; p++) begin
				if (hrf && !m_prev) begin
					s_on[p] <= tw[p] ? onw[p] : onc[p];
					s_off[p] <= tw[p] ? offw[p] : offc[p];
				end else if (hrf && tick && m_rc && tw[p]) begin
					s_on[p] <= onw[p];
					s_off[p] <= offw[p];
				end
			end
			m_out <= !hrf ? '0 : m_ev ? exp_out() : m_out;
		end
	end

	always @(negedge clk) begin
		tests_run += 2;
		if (rcf !== m_rc) begin
			n_fail++;
			$display("[ERR] ready_complete_flag expected %b seen %b", m_rc, rcf);
		end
		if (lo !== m_out) begin
			n_fail++;
			$display("[ERR] limit_out expected %b seen %b", m_out, lo);
		end
	end

	// Small signed values make every region edge and sign likely
	function automatic logic [WORD_W-1:0] rv(input logic [DTYPE_W-1:0] t);
		int v;
		v = int'($urandom_range(0, 15)) - 8;
		if (t == DT_FLOAT64) return $realtobits(real'(v));
		return {$urandom, 32'(v)};
	endfunction

	task automatic live();
		for (int p = 0; p < P; p++) begin
			wv[p] <= rv(dt[p]);
			onw[p] <= rv(dt[p]);
			offw[p] <= rv(dt[p]);
			eb[p] <= 1'($urandom);
			fb[p] <= ($urandom_range(0, 3) == 0);
		end
	endtask

	task automatic setup();
		logic [DTYPE_W-1:0] t;
		for (int p = 0; p < P; p++) begin
			t = 2'($urandom_range(0, 3));
			dt[p] <= t;
			pu[p] <= ($urandom_range(0, 4) != 0);
			sel[p] <= 2'($urandom_range(0, 3));
			tw[p] <= 1'($urandom);
			eu[p] <= 1'($urandom);
			fu[p] <= 1'($urandom);
			onc[p] <= rv(t);
			offc[p] <= rv(t);
		end
	endtask

	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#80000;
		n_fail++;
		end_sim();
	end

	initial begin
		{pu, tw, eu, fu, eb, fb, sel, dt} = '0;
		{wv, onw, offw, onc, offc} = '0;
		resetn = 1'b0;
		ready_req = 1'b0;
		void'($urandom(32'h5141));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int r = 0; r < 40; r++) begin
			@(posedge clk);
			ready_req <= 1'b0;
			resetn <= (r != 20);
			repeat ($urandom_range(1, 3)) @(posedge clk);
			resetn <= 1'b1;
			setup();
			live();
			ready_req <= 1'b1;
			repeat (30) begin
				@(posedge clk);
				live();
			end
		end
		end_sim();
	end
endmodule // tb

`default_nettype wire
